// ---- src/sfl_flash_core.sv ----
// serial flash instruction core: serial front end on the link clock, array and timed cycles on core_clk
// assumes select high while the serial clock is idle; the array is not initialised by reset
`timescale 1ns/100ps
module sfl_flash_core #(
  parameter int unsigned PROG_CYCLES = sfl_pkg::PROG_CYCLES,
  parameter int unsigned SE_CYCLES   = sfl_pkg::SE_CYCLES,
  parameter int unsigned BE_CYCLES   = sfl_pkg::BE_CYCLES
) (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // serial link
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_d,
  output logic            spi_q,
  output logic            spi_q_oe,
  // configuration and status
  input  wire logic [2:0] block_guard_bits,
  output logic            write_in_progress_flag,
  output logic            write_unlock_latch,
  output logic            deep_sleep_active
);

  // array and page buffer
  // the array has no reset: a real part keeps its contents over power cycles,
  // so the first erase after start-up is what gives it defined values
  logic [7:0]  mem_q [sfl_pkg::ARR_BYTES];
  logic [7:0]  buf_q [sfl_pkg::PAGE_BYTES];
  logic [255:0] mask_q;

  // link side state
  // these registers run only while the serial clock toggles, so they carry no reset;
  // every frame rebuilds them from its first edge onward
  logic        fresh_q;
  logic [7:0]  sh_q;
  logic [2:0]  bit_cnt_q;
  logic [2:0]  byte_cnt_q;
  logic [7:0]  opcode_q;
  logic [18:0] addr_q;
  logic [7:0]  pg_ptr_q;
  logic [18:0] rd_addr_q;
  logic        q_q;
  logic        oe_q;
  logic        busy_s1_q;
  logic        busy_s2_q;
  logic        sleep_s1_q;
  logic        sleep_s2_q;
  logic [2:0]  bit_now;
  logic [2:0]  byte_now;
  logic [7:0]  byte_in;
  logic        link_ok;
  logic        byte_done;

  // core side state
  // everything below runs on core_clk and is judged only once select has settled high
  sfl_pkg::sfl_state_e state_q;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic [2:0]  guard_s1_q;
  logic [2:0]  guard_s2_q;
  logic        wel_q;
  logic        sleep_q;
  logic        sleep_pend_q;
  logic [15:0] sleep_cnt_q;
  logic [19:0] walk_q;
  logic [19:0] walk_end_q;
  logic [31:0] tmr_q;
  logic [31:0] limit_q;
  logic [18:0] base_q;
  logic        frame_end;
  logic        busy;
  logic        exact_cmd;
  logic        exact_addr;
  logic        data_ok;
  logic        addr_guarded;
  logic [3:0]  guard_cnt;

  // frame start marker: select high forces it, first serial edge clears it
  always_ff @(posedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  // counts restart at the first edge of a frame but hold after it so the core can judge the frame
  assign bit_now   = fresh_q ? 3'h0 : bit_cnt_q;
  assign byte_now  = fresh_q ? 3'h0 : byte_cnt_q;
  assign byte_in   = {sh_q[6:0], spi_d};
  assign byte_done = (bit_now == 3'h7);
  assign link_ok   = !busy_s2_q && !sleep_s2_q;

  // busy and sleep levels into the link domain
  // these only advance on serial edges, so the first two edges of a frame still see the
  // previous frame's view; data output starts many edges later, which hides that lag
  always_ff @(posedge spi_sclk)
  begin
    busy_s1_q  <= (state_q != sfl_pkg::SFL_IDLE);
    busy_s2_q  <= busy_s1_q;
    sleep_s1_q <= sleep_q | sleep_pend_q;
    sleep_s2_q <= sleep_s1_q;
  end

  // shift, bit and byte counting on rising serial edges
  always_ff @(posedge spi_sclk)
  begin
    sh_q      <= byte_in;
    bit_cnt_q <= bit_now + 3'h1;
    if (byte_done && byte_now != sfl_pkg::BYTES_MAX)
      byte_cnt_q <= byte_now + 3'h1;
    else
      byte_cnt_q <= byte_now;
  end

  // opcode and address capture; the top five address bits are simply never stored
  always_ff @(posedge spi_sclk)
  begin
    if (byte_done)
    begin
      case (byte_now)
        3'h0:    opcode_q <= byte_in;
        3'h1:    addr_q[18:16] <= byte_in[2:0];
        3'h2:    addr_q[15:8] <= byte_in;
        3'h3:    addr_q[7:0] <= byte_in;
        default: ;
      endcase
    end
  end

  // page buffer fill; the pointer wraps within 256 so later bytes overwrite earlier ones
  // the mask remembers which offsets were sent, so the walk leaves the rest of the page alone
  // a refused frame may still fill the buffer; harmless, since only an accepted frame starts the walk
  always_ff @(posedge spi_sclk)
  begin
    if (byte_done && byte_now == 3'h0 && byte_in == sfl_pkg::OP_PROGRAM && link_ok)
      mask_q <= '0;
    if (byte_done && byte_now == 3'h3)
      pg_ptr_q <= byte_in;
    if (byte_done && byte_now >= sfl_pkg::BYTES_ADDR && opcode_q == sfl_pkg::OP_PROGRAM && link_ok)
    begin
      buf_q[pg_ptr_q]  <= byte_in;
      mask_q[pg_ptr_q] <= 1'b1;
      pg_ptr_q         <= pg_ptr_q + 8'h01;
    end
  end

  // read address: loaded with the last address byte, stepped after each output byte
  always_ff @(posedge spi_sclk)
  begin
    if (byte_done && byte_now == 3'h3)
      rd_addr_q <= {addr_q[18:8], byte_in};
    else if (byte_done && byte_now >= sfl_pkg::BYTES_DATA)
      rd_addr_q <= rd_addr_q + 19'h00001;
  end

  // data out on falling edges; select high drops the driver at once, even mid-byte
  // the array is read across domains, safe because it is only written while reads are refused
  always_ff @(negedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      q_q  <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (opcode_q == sfl_pkg::OP_FAST_READ && byte_cnt_q >= sfl_pkg::BYTES_DATA && link_ok)
    begin
      q_q  <= mem_q[rd_addr_q][~bit_cnt_q];
      oe_q <= 1'b1;
    end
    else
    begin
      q_q  <= 1'b0;
      oe_q <= 1'b0;
    end
  end

  assign spi_q    = q_q;
  assign spi_q_oe = oe_q;

  // select and guard pins into the core domain
  // a third select stage gives a clean one-cycle rising edge for the frame verdict
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cs_s1_q    <= 1'b1;
      cs_s2_q    <= 1'b1;
      cs_s3_q    <= 1'b1;
      guard_s1_q <= 3'h0;
      guard_s2_q <= 3'h0;
    end
    else
    begin
      cs_s1_q    <= spi_cs_n;
      cs_s2_q    <= cs_s1_q;
      cs_s3_q    <= cs_s2_q;
      guard_s1_q <= block_guard_bits;
      guard_s2_q <= guard_s1_q;
    end
  end

  // frame verdict: link registers are still because the serial clock stops with select high
  assign frame_end  = cs_s2_q && !cs_s3_q;
  assign busy       = (state_q != sfl_pkg::SFL_IDLE);
  assign exact_cmd  = (byte_cnt_q == sfl_pkg::BYTES_CMD) && (bit_cnt_q == 3'h0);
  assign exact_addr = (byte_cnt_q == sfl_pkg::BYTES_ADDR) && (bit_cnt_q == 3'h0);
  assign data_ok    = (byte_cnt_q >= sfl_pkg::BYTES_DATA) && (bit_cnt_q == 3'h0);

  // guarded sectors counted from the top: 1, 2, 4, then all eight
  assign guard_cnt    = (guard_s2_q == 3'h0) ? 4'h0 :
                        (guard_s2_q >= 3'h4) ? 4'h8 : 4'(4'h1 << (guard_s2_q - 3'h1));
  assign addr_guarded = ({1'b0, addr_q[18:16]} >= (4'h8 - guard_cnt)) && (guard_cnt != 4'h0);

  // unlock latch: set by its command, dropped as any timed cycle starts
  // clearing at the start rather than the end keeps a second write from sneaking in mid-cycle;
  // a refused write leaves the latch as it was so the host can retry without a new unlock
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wel_q <= 1'b0;
    else if (frame_end && !busy && !sleep_q && !sleep_pend_q)
    begin
      if (opcode_q == sfl_pkg::OP_UNLOCK && exact_cmd)
        wel_q <= 1'b1;
      else if (state_q == sfl_pkg::SFL_IDLE && wel_q &&
               ((opcode_q == sfl_pkg::OP_PROGRAM && data_ok && !addr_guarded) ||
                (opcode_q == sfl_pkg::OP_SEC_ERASE && exact_addr && !addr_guarded) ||
                (opcode_q == sfl_pkg::OP_BLK_ERASE && exact_cmd && guard_s2_q == 3'h0)))
        wel_q <= 1'b0;
    end
  end

  // deep sleep: entry after a fixed delay, exit on wake; refused while a cycle runs
  // while entry is pending every frame is ignored, the wake command included
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sleep_q      <= 1'b0;
      sleep_pend_q <= 1'b0;
      sleep_cnt_q  <= 16'h0000;
    end
    else if (sleep_pend_q)
    begin
      sleep_cnt_q <= sleep_cnt_q + 16'h0001;
      if (sleep_cnt_q == sfl_pkg::SLEEP_CYCLES - 16'h0001)
      begin
        sleep_pend_q <= 1'b0;
        sleep_q      <= 1'b1;
      end
    end
    else if (frame_end && !busy)
    begin
      if (sleep_q && opcode_q == sfl_pkg::OP_WAKE && byte_cnt_q != 3'h0)
        sleep_q <= 1'b0;
      else if (!sleep_q && opcode_q == sfl_pkg::OP_SLEEP && exact_cmd)
      begin
        sleep_pend_q <= 1'b1;
        sleep_cnt_q  <= 16'h0000;
      end
    end
  end

  // cycle engine: start on a valid frame end, walk the bytes, finish when walk and timer are done
  // limitation: the walk costs one clock per byte, so a cycle never ends before its whole
  // region has been touched even when the timer parameter is set shorter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q    <= sfl_pkg::SFL_IDLE;
      walk_q     <= 20'h00000;
      walk_end_q <= 20'h00000;
      tmr_q      <= 32'h00000000;
      limit_q    <= 32'h00000000;
      base_q     <= 19'h00000;
    end
    else
    begin
      case (state_q)
        sfl_pkg::SFL_IDLE:
        begin
          walk_q <= 20'h00000;
          tmr_q  <= 32'h00000000;
          if (frame_end && wel_q && !sleep_q && !sleep_pend_q)
          begin
            if (opcode_q == sfl_pkg::OP_PROGRAM && data_ok && !addr_guarded)
            begin
              state_q    <= sfl_pkg::SFL_PROG;
              base_q     <= {addr_q[18:8], 8'h00};
              walk_end_q <= 20'(sfl_pkg::PAGE_BYTES);
              limit_q    <= 32'(PROG_CYCLES);
            end
            else if (opcode_q == sfl_pkg::OP_SEC_ERASE && exact_addr && !addr_guarded)
            begin
              state_q    <= sfl_pkg::SFL_SERASE;
              base_q     <= {addr_q[18:16], 16'h0000};
              walk_end_q <= 20'(sfl_pkg::SEC_BYTES);
              limit_q    <= 32'(SE_CYCLES);
            end
            else if (opcode_q == sfl_pkg::OP_BLK_ERASE && exact_cmd && guard_s2_q == 3'h0)
            begin
              state_q    <= sfl_pkg::SFL_BERASE;
              base_q     <= 19'h00000;
              walk_end_q <= 20'(sfl_pkg::ARR_BYTES);
              limit_q    <= 32'(BE_CYCLES);
            end
          end
        end
        default:
        begin
          if (walk_q != walk_end_q)
            walk_q <= walk_q + 20'h00001;
          if (tmr_q != limit_q)
            tmr_q <= tmr_q + 32'h00000001;
          if (walk_q == walk_end_q && tmr_q == limit_q)
            state_q <= sfl_pkg::SFL_IDLE;
        end
      endcase
    end
  end

  // array writes: one byte per clock; programming only clears bits
  // single-port style access keeps the array inferable as a plain memory
  always_ff @(posedge core_clk)
  begin
    if (state_q == sfl_pkg::SFL_PROG && walk_q != walk_end_q)
    begin
      if (mask_q[walk_q[7:0]])
        mem_q[{base_q[18:8], walk_q[7:0]}] <= mem_q[{base_q[18:8], walk_q[7:0]}] & buf_q[walk_q[7:0]];
    end
    else if ((state_q == sfl_pkg::SFL_SERASE || state_q == sfl_pkg::SFL_BERASE) && walk_q != walk_end_q)
      mem_q[base_q + walk_q[18:0]] <= sfl_pkg::ERASED;
  end

  // status outputs straight from registers
  // the busy flag is the engine state itself, so it cannot disagree with the walk
  assign write_in_progress_flag = busy;
  assign write_unlock_latch     = wel_q;
  assign deep_sleep_active      = sleep_q;

endmodule : sfl_flash_core

// ---- src/sfl_pkg.sv ----
// constants, opcodes and state type for the serial flash instruction core
// assumes a 100 MHz core clock and a serial clock that only runs inside frames
package sfl_pkg;

  // opcode values, arbitrary encodings
  localparam logic [7:0] OP_UNLOCK    = 8'h11;
  localparam logic [7:0] OP_FAST_READ = 8'h22;
  localparam logic [7:0] OP_PROGRAM   = 8'h33;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_BLK_ERASE = 8'h55;
  localparam logic [7:0] OP_SLEEP     = 8'h66;
  localparam logic [7:0] OP_WAKE      = 8'h77;

  // array geometry: 19 address bits kept, 8 sectors, 256-byte pages
  localparam int unsigned ADDR_W     = 19;
  localparam int unsigned SEC_LSB    = 16;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned SEC_BYTES  = 65536;
  localparam int unsigned ARR_BYTES  = 524288;
  localparam logic [7:0]  ERASED     = 8'hFF;

  // frame byte counts: opcode is byte 0
  localparam logic [2:0] BYTES_CMD  = 3'h1;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_DATA = 3'h5;
  localparam logic [2:0] BYTES_MAX  = 3'h7;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned PROG_TIME_US   = 100;
  localparam int unsigned SE_TIME_US     = 2000;
  localparam int unsigned BE_TIME_US     = 8000;
  localparam int unsigned SLEEP_DELAY_NS = 3000;
  localparam int unsigned PROG_CYCLES    = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SE_CYCLES      = (SE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BE_CYCLES      = (BE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] SLEEP_CYCLES   = 16'((SLEEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // self-timed cycle engine states
  typedef enum logic [1:0] {SFL_IDLE, SFL_PROG, SFL_SERASE, SFL_BERASE} sfl_state_e;

endpackage : sfl_pkg

// ---- tb/sfl_core_checker.sv ----
// checker: link and status relations of the flash core
// assumes binding to sfl_flash_core, all checks on core_clk
`timescale 1ns/100ps
module sfl_core_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link
  input wire logic spi_cs_n,
  input wire logic spi_q,
  input wire logic spi_q_oe,
  // status
  input wire logic write_in_progress_flag,
  input wire logic write_unlock_latch,
  input wire logic deep_sleep_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // a cycle starts only after a frame end and consumes the latch
  sequence frame_ended;
    $past(spi_cs_n, 2) && !write_unlock_latch;
  endsequence
  // a started cycle is far longer than eight clocks
  sequence busy_hold;
    write_in_progress_flag [*8];
  endsequence

  oe_idle_a: assert property (spi_cs_n |-> !spi_q_oe) else $error("output enabled while deselected");
  q_quiet_a: assert property (!spi_q_oe |-> !spi_q) else $error("data driven while disabled");
  read_gate_a: assert property ($rose(spi_q_oe) |-> !write_in_progress_flag && !deep_sleep_active)
    else $error("read answered while busy or asleep");
  cycle_start_a: assert property ($rose(write_in_progress_flag) |-> frame_ended)
    else $error("cycle start without frame end or latch kept");
  latch_need_a: assert property ($rose(write_in_progress_flag) |-> $past(write_unlock_latch))
    else $error("cycle started with latch clear");
  busy_len_a: assert property ($rose(write_in_progress_flag) |-> busy_hold) else $error("cycle too short");
  sleep_delay_a: assert property ($rose(deep_sleep_active) |-> $past(spi_cs_n, 250) && !write_in_progress_flag)
    else $error("sleep entered early or while busy");
  sleep_lock_a: assert property ($rose(write_unlock_latch) |-> !$past(deep_sleep_active))
    else $error("unlock taken while asleep");
endmodule : sfl_core_checker

// ---- tb/sfl_host_model.sv ----
// host model: mode 0 serial master with a 15 ns link clock, only inside frames
// assumes the bench calls frame() and reads rx_q and oe_seen afterwards
`timescale 1ns/100ps
module sfl_host_model (
  // serial link toward the core
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_d,
  input  wire logic spi_q,
  input  wire logic spi_q_oe
);
  logic [7:0] rx_q [$];
  logic       oe_seen;
  logic       q_smp;

  // link idle: select high, clock parked low
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_d    = 1'b0;
    oe_seen  = 1'b0;
  end

  // one bit: data set in the low phase, both sides sample at the rise
  task automatic tick(input logic b);
    spi_d = b;
    #3.75 spi_sclk = 1'b1;
    q_smp = spi_q;
    oe_seen = oe_seen | spi_q_oe;
    #7.5 spi_sclk = 1'b0;
    #3.75;
  endtask : tick

  // whole frame; extra bits break the byte framing on purpose
  task automatic frame(input logic [7:0] tx [$], input int nrd, input int extra);
    logic [7:0] b;
    rx_q.delete();
    oe_seen = 1'b0;
    spi_cs_n = 1'b0;
    #7.5;
    foreach (tx[i]) for (int k = 7; k >= 0; k--) tick(tx[i][k]);
    repeat (nrd)
    begin
      for (int k = 7; k >= 0; k--)
      begin
        tick(~spi_d);
        b[k] = q_smp;
      end
      rx_q.push_back(b);
    end
    repeat (extra) tick(1'b1);
    #7.5 spi_cs_n = 1'b1;
    spi_d = ~spi_d;
    #100;
  endtask : frame
endmodule : sfl_host_model

// ---- tb/testbench.sv ----
// testbench: drives the flash core through the host model and checks status and read data
// assumes shortened cycle parameters; only sector 0 is erased, so only its bytes are checked on read back
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  typedef logic [7:0] sfl_tb_bq_t [$];
  logic       core_clk, rst_n, spi_sclk, spi_cs_n, spi_d, spi_q, spi_q_oe;
  logic       write_in_progress_flag, write_unlock_latch, deep_sleep_active;
  logic [2:0] block_guard_bits;
  logic [7:0] d0, d1;
  sfl_tb_bq_t dq;
  int         bad_count, compares, cyc, n;

  always #5 core_clk = ~core_clk;

  sfl_flash_core #(.PROG_CYCLES(10), .SE_CYCLES(10), .BE_CYCLES(10)) sfl_flash_core_inst (.core_clk(core_clk),
    .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_d(spi_d), .spi_q(spi_q), .spi_q_oe(spi_q_oe),
    .block_guard_bits(block_guard_bits), .write_in_progress_flag(write_in_progress_flag),
    .write_unlock_latch(write_unlock_latch), .deep_sleep_active(deep_sleep_active));
  sfl_host_model sfl_host_model_inst (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_d(spi_d), .spi_q(spi_q),
    .spi_q_oe(spi_q_oe));

  function automatic sfl_tb_bq_t hdr(input logic [7:0] op, input logic [23:0] a);
    return '{op, a[23:16], a[15:8], a[7:0]};
  endfunction : hdr
  // page wraps at 256 and the last byte sent to an offset wins
  function automatic logic [7:0] pg_exp(input sfl_tb_bq_t d, input logic [7:0] st, input logic [7:0] off);
    pg_exp = 8'hFF;
    foreach (d[i]) if (8'(st + i) == off) pg_exp = d[i];
  endfunction : pg_exp

  task automatic frm(input sfl_tb_bq_t tx, input int nrd = 0, input int extra = 0);
    sfl_host_model_inst.frame(tx, nrd, extra);
  endtask : frm
  task automatic rd(input logic [23:0] a, input int nrd, input int extra = 0);
    frm({hdr(sfl_pkg::OP_FAST_READ, a), 8'h00}, nrd, extra);
  endtask : rd
  task automatic wr(input sfl_tb_bq_t tx);
    frm('{sfl_pkg::OP_UNLOCK});
    frm(tx);
  endtask : wr
  // bounded wait for the self-timed cycle to finish
  task automatic idle(input int lim);
    n = 0;
    while (write_in_progress_flag !== 1'b0 && n < lim) begin @(posedge core_clk); n++; end
    `CHK(write_in_progress_flag, 1'b0)
  endtask : idle
  // a refused write leaves the engine idle
  task automatic refuse(input sfl_tb_bq_t tx, input int extra = 0);
    frm(tx, 0, extra);
    repeat (10) @(posedge core_clk);
    `CHK(write_in_progress_flag, 1'b0)
  endtask : refuse
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // hang guard: whole run needs about 75k clocks
  always @(posedge core_clk) begin cyc++; if (cyc == 100000) begin bad_count++; final_report(); end end

  initial
  begin
    core_clk = 1'b0; rst_n = 1'b0; block_guard_bits = 3'h0; bad_count = 0; compares = 0; cyc = 0;
    void'($urandom(32'h191d5f41));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK({write_in_progress_flag, write_unlock_latch, deep_sleep_active}, 3'h0)
    refuse({hdr(sfl_pkg::OP_PROGRAM, 24'h0), 8'h00});
    $display("test no_unlock finished");
    wr(hdr(sfl_pkg::OP_SEC_ERASE, 24'hF80123));
    `CHK({write_in_progress_flag, write_unlock_latch}, 2'h2)
    rd(24'h0, 1);
    `CHK(sfl_host_model_inst.oe_seen, 1'b0)
    frm('{sfl_pkg::OP_SLEEP});
    repeat (400) @(posedge core_clk);
    `CHK(deep_sleep_active, 1'b0)
    idle(70000);
    rd(24'h000010, 2);
    `CHK({sfl_host_model_inst.rx_q[0], sfl_host_model_inst.rx_q[1]}, 16'hFFFF)
    $display("test sector_erase finished");
    dq = '{};
    repeat (258) dq.push_back(8'($urandom));
    wr({hdr(sfl_pkg::OP_PROGRAM, 24'h0001FE), dq});
    idle(2000);
    rd(24'h000100, 4);
    for (int i = 0; i < 4; i++) `CHK(sfl_host_model_inst.rx_q[i], pg_exp(dq, 8'hFE, 8'(i)))
    rd(24'h0001FE, 2);
    for (int i = 0; i < 2; i++) `CHK(sfl_host_model_inst.rx_q[i], pg_exp(dq, 8'hFE, 8'(8'hFE + i)))
    $display("test page_wrap finished");
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    wr({hdr(sfl_pkg::OP_PROGRAM, 24'h0), d0});
    idle(2000);
    wr({hdr(sfl_pkg::OP_PROGRAM, 24'h0), d1});
    idle(2000);
    rd(24'hFFFFFF, 3);
    `CHK(sfl_host_model_inst.rx_q[1], d0 & d1)
    `CHK(sfl_host_model_inst.rx_q[2], 8'hFF)
    rd(24'h0, 1, 3);
    `CHK(sfl_host_model_inst.oe_seen, 1'b1)
    `CHK(spi_q_oe, 1'b0)
    $display("test partial_program finished");
    frm('{sfl_pkg::OP_UNLOCK});
    refuse({hdr(sfl_pkg::OP_PROGRAM, 24'h000020), 8'h00}, 3);
    refuse({hdr(sfl_pkg::OP_SEC_ERASE, 24'h0), 8'h00});
    refuse('{sfl_pkg::OP_BLK_ERASE}, 1);
    block_guard_bits <= 3'h1;
    refuse('{sfl_pkg::OP_BLK_ERASE});
    refuse({hdr(sfl_pkg::OP_PROGRAM, 24'h070000), 8'h00});
    refuse(hdr(sfl_pkg::OP_SEC_ERASE, 24'h070000));
    `CHK(write_unlock_latch, 1'b1)
    $display("test refusals finished");
    block_guard_bits <= 3'h0;
    frm('{sfl_pkg::OP_SLEEP});
    n = 0;
    while (deep_sleep_active !== 1'b1 && n < 400) begin @(posedge core_clk); n++; end
    `CHK(n > 270 && n < 310, 1'b1)
    rd(24'h0, 1);
    `CHK(sfl_host_model_inst.oe_seen, 1'b0)
    refuse('{sfl_pkg::OP_BLK_ERASE});
    frm('{sfl_pkg::OP_WAKE});
    `CHK(deep_sleep_active, 1'b0)
    rd(24'h0, 1);
    `CHK(sfl_host_model_inst.rx_q[0], d0 & d1)
    $display("test deep_sleep finished");
    final_report();
  end
endmodule : testbench

bind sfl_flash_core sfl_core_checker checker_inst (.core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
  .spi_q(spi_q), .spi_q_oe(spi_q_oe), .write_in_progress_flag(write_in_progress_flag),
  .write_unlock_latch(write_unlock_latch), .deep_sleep_active(deep_sleep_active));
